// ### ir_xcvr_if.v
// Infrared transceiver module interface with APB register slave
`timescale 1ns/1ns
`include "ir_xcvr_map.vh"
module ir_xcvr_if
(
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    input  wire [7:0]  paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        power_down_n,
    input  wire        ir_rx_in_a,
    input  wire        ir_rx_in_b,
    input  wire        tx_data,
    output reg         ir_tx_out,
    output reg         module_shutdown_out,
    output reg         rx_pulse,
    output reg         osc_stop,
    output reg         powered_down
);
    // ********************************************************
    // Declarations
    // ********************************************************
    localparam [2:0] S_IDLE = 3'b001;
    localparam [2:0] S_HIGH = 3'b010;
    localparam [2:0] S_TAIL = 3'b100;
    localparam integer STEP_LAST_I = `STEP_CYCLES - 1;
    localparam [4:0] STEP_LAST = STEP_LAST_I[4:0];

    wire [2:0] pins_sync;
    wire       pdn_s;
    wire       rx_a_s;
    wire       rx_b_s;
    wire       pd_active;
    wire       wr_en;
    // Per-register write strobes
    wire       wr_ctrl;
    wire       wr_cfg;
    wire       wr_ms;
    wire       rd_setup;
    wire [5:0] idx;
    wire       mapped;
    wire       xtal_slow;
    wire       is_fir;
    wire [3:0] speed_req;
    wire [3:0] speed_eff;
    wire       speed_limited;
    wire       use_b;
    wire       rx_raw;
    wire       busy;
    wire       start_seq;
    wire       step_done;

    reg  [7:0] ctrl_q;
    reg  [7:0] cfg_q;
    reg  [7:0] ms_q;
    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg  [4:0] cnt_q;
    reg  [4:0] cnt_d;
    reg        seq_sd;
    reg        seq_tx;
    reg        seq_drive;
    reg  [7:0] rd_byte;

    // ********************************************************
    // Register index decode, shared by read and write paths
    // ********************************************************
    // Unaligned addresses miss every register and draw pslverr
    function hit;
        input [7:0] addr;
        input [5:0] index;
        begin
            hit = (addr[1:0] == 2'h0) && (addr[7:2] == index);
        end
    endfunction

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    pin_sync #(.WIDTH(3)) u_sync
    (
        .clk      (clk),
        .srst     (srst),
        .ce       (ce),
        .async_in ({power_down_n, ir_rx_in_b, ir_rx_in_a}),
        .sync_out (pins_sync)
    );

    // Reset loads ones: pins read idle, power-down not asserted
    assign pdn_s     = pins_sync[2];
    assign rx_b_s    = pins_sync[1];
    assign rx_a_s    = pins_sync[0];
    assign pd_active = ~pdn_s;

    // ********************************************************
    // APB access decode
    // ********************************************************
    assign idx      = paddr[7:2];
    assign mapped   = hit(paddr, `IDX_CTRL_PRIMARY) | hit(paddr, `IDX_XCVR_CONFIG)
                    | hit(paddr, `IDX_MODE_SPEED) | hit(paddr, `IDX_STATUS);
    // Write lands only at the completing edge, lane 0 only
    assign wr_en    = psel & penable & pready & pwrite & pstrb[0] & mapped;
    assign rd_setup = psel & ~penable;

    // One decode per register, shared by register file and sequencer
    assign wr_ctrl  = wr_en & hit(paddr, `IDX_CTRL_PRIMARY);
    assign wr_cfg   = wr_en & hit(paddr, `IDX_XCVR_CONFIG);
    assign wr_ms    = wr_en & hit(paddr, `IDX_MODE_SPEED);

    // ********************************************************
    // Mode and speed derivation
    // ********************************************************
    assign xtal_slow     = ms_q[`BIT_XTAL_SEL];
    assign is_fir        = ms_q[`MODE_MSB:`MODE_LSB] == `MODE_FIR;
    assign speed_req     = ms_q[`SPEED_MSB:`SPEED_LSB];
    // Clamp keeps input selection consistent with the real rate
    // Slow crystal cannot make 4 Mbps; clamp rather than fault
    assign speed_limited = xtal_slow && (speed_req >= `SPEED_4M);
    assign speed_eff     = speed_limited ? `SPEED_1M152 : speed_req;

    // ********************************************************
    // Receive input selection and polarity
    // ********************************************************
    // Input B only at fast speeds; single-output modules tie it off
    assign use_b  = cfg_q[`BIT_RX_SEL] && (speed_eff >= `SPEED_FIRST_FAST);
    assign rx_raw = use_b ? rx_b_s : rx_a_s;

    // ********************************************************
    // Mode-setting sequencer
    // ********************************************************
    // High and tail steps each last STEP_CYCLES cycles
    // Pins lag the state by one flop, so the walk shows a cycle late
    // A start that lands while busy is dropped, not queued
    assign busy      = ~state_q[0];
    // Sequence is refused on slow crystal or while powered down
    assign start_seq = wr_ctrl && pwdata[`BIT_MODE_SET]
                     && !busy && !xtal_slow && !pd_active;
    assign step_done = cnt_q == STEP_LAST;

    // Next state and step counter
    always @*
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            S_IDLE:
            begin
                cnt_d = 5'h00;
                if (start_seq)
                    state_d = S_HIGH;
            end
            S_HIGH:
            begin
                cnt_d = cnt_q + 5'h01;
                if (step_done)
                begin
                    cnt_d   = 5'h00;
                    state_d = S_TAIL;
                end
            end
            S_TAIL:
            begin
                cnt_d = cnt_q + 5'h01;
                if (step_done)
                begin
                    cnt_d   = 5'h00;
                    state_d = S_IDLE;
                end
            end
            default:
            begin
                cnt_d   = 5'h00;
                state_d = S_IDLE;
            end
        endcase
        // Oscillator stops in power-down, so the sequence is abandoned
        if (pd_active)
        begin
            cnt_d   = 5'h00;
            state_d = S_IDLE;
        end
    end

    // Polarity is applied at the pin flop, not here
    // Active-high pin levels for each sequence step
    always @*
    begin
        seq_sd    = 1'b0;
        seq_tx    = 1'b0;
        seq_drive = 1'b0;
        case (state_q)
            S_IDLE:
            begin
                seq_drive = 1'b0;
            end
            S_HIGH:
            begin
                seq_drive = 1'b1;
                seq_sd    = 1'b1;
                seq_tx    = is_fir;
            end
            S_TAIL:
            begin
                seq_drive = 1'b1;
                seq_sd    = 1'b0;
                seq_tx    = is_fir;
            end
            default:
            begin
                seq_drive = 1'b0;
            end
        endcase
    end

    // State and step counter advance only with clock enable
    always @(posedge clk)
    begin
        if (srst)
        begin
            state_q <= S_IDLE;
            cnt_q   <= 5'h00;
        end
        else if (ce)
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // ********************************************************
    // Register file
    // ********************************************************
    // Writes land at the completing edge; read-only bits dropped here
    always @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_q <= `RST_CTRL_PRIMARY;
            cfg_q  <= `RST_XCVR_CONFIG;
            ms_q   <= `RST_MODE_SPEED;
        end
        else if (ce)
        begin
            if (wr_ctrl)
            begin
                ctrl_q[6:0] <= pwdata[6:0];
            end
            // Set on start wins; clear only when the walk ends
            if (start_seq)
                ctrl_q[`BIT_MODE_SET] <= 1'b1;
            else if (!busy || state_d == S_IDLE)
                ctrl_q[`BIT_MODE_SET] <= 1'b0;
            if (wr_cfg)
                cfg_q <= {1'b0, pwdata[6:4], 4'h0};
            if (wr_ms)
                ms_q <= {1'b0, pwdata[6:0]};
        end
    end

    // ********************************************************
    // APB read data and handshake
    // ********************************************************
    // Read mux on the word index; spare words return zero
    always @*
    begin
        rd_byte = 8'h00;
        case (idx)
            `IDX_CTRL_PRIMARY: rd_byte = ctrl_q;
            `IDX_XCVR_CONFIG:  rd_byte = cfg_q;
            `IDX_MODE_SPEED:   rd_byte = ms_q;
            `IDX_STATUS:       rd_byte = {2'h0, speed_limited, busy, use_b, rx_raw, rx_pulse, pd_active};
            default:           rd_byte = 8'h00;
        endcase
    end

    // prdata holds until the next setup, so a slow master still sees it
    // Answer one cycle after setup: zero-wait access phase
    always @(posedge clk)
    begin
        if (srst)
        begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else if (ce)
        begin
            pready  <= rd_setup;
            pslverr <= rd_setup & ~mapped;
            if (rd_setup && !pwrite && mapped)
                prdata <= {24'h00_0000, rd_byte};
            else if (rd_setup)
                prdata <= 32'h0000_0000;
        end
    end

    // ********************************************************
    // Transceiver pins
    // ********************************************************
    // Every pin straight from a flop, so no glitch reaches the module
    always @(posedge clk)
    begin
        if (srst)
        begin
            module_shutdown_out <= 1'b0;
            ir_tx_out           <= 1'b0;
            rx_pulse            <= 1'b0;
            osc_stop            <= 1'b0;
            powered_down        <= 1'b0;
        end
        else if (ce)
        begin
            // Active-high level, then inverted for an active-low module
            module_shutdown_out <= (pd_active | seq_sd) ^ cfg_q[`BIT_SD_POL];
            // Power-down first, then sequence; receive mode beats transmit
            if (pd_active)
                ir_tx_out <= 1'b0;
            else if (seq_drive)
                ir_tx_out <= seq_tx;
            else
                ir_tx_out <= tx_data & ctrl_q[`BIT_TX_EN] & ~ctrl_q[`BIT_RX_EN];
            // Gated in power-down so a dead module never reads as a pulse
            // Normalised to active high for the receive path
            rx_pulse     <= ~pd_active & ctrl_q[`BIT_RX_EN] & (rx_raw ^ ~cfg_q[`BIT_RX_POL]);
            osc_stop     <= pd_active;
            powered_down <= pd_active;
        end
    end
endmodule // ir_xcvr_if

// ### ir_xcvr_map.vh
// Register map, field positions, reset values and timing counts of the transceiver interface
// Summary of operation
// - Shutdown output follows power-down input except during mode-set sequence
// - Polarity one: power-down drives shutdown low
// - Polarity zero: power-down drives shutdown high
// - Power-down input puts device in power-down
// - Config bits 6,5,4 at index 5
// - Select one: A up to 115.2k, B above
// - Select zero: only input A, B ignored
// - Receive polarity zero low, one high
// - Mode-set bit starts sequence, self-clears after
// - FIR: both high, shutdown drops, transmit drops
// - Other modes: shutdown pulse, transmit held low
// - Active-low shutdown inverts sequence shutdown levels
// - Crystal select bit 4 at index 6
// - Slow crystal limits speed to 1.152 Mbps
// - Transmit output is active high
// - Power-down stops oscillator, low current
`ifndef IR_XCVR_MAP_VH
`define IR_XCVR_MAP_VH

// ********************************************************
// Register indices; byte address is four times the index
// ********************************************************
`define IDX_CTRL_PRIMARY    6'h04
`define IDX_XCVR_CONFIG     6'h05
`define IDX_MODE_SPEED      6'h06
`define IDX_STATUS          6'h08

// ********************************************************
// Field positions
// ********************************************************
`define BIT_TX_EN           0
`define BIT_RX_EN           1
`define BIT_MODE_SET        7
`define BIT_RX_POL          4
`define BIT_RX_SEL          5
`define BIT_SD_POL          6
`define BIT_XTAL_SEL        4
`define SPEED_LSB           0
`define SPEED_MSB           3
`define MODE_LSB            5
`define MODE_MSB            6

// ********************************************************
// Encodings and reset values
// ********************************************************
`define MODE_FIR            2'h3
`define SPEED_FIRST_FAST    4'h6
`define SPEED_1M152         4'h7
`define SPEED_4M            4'h8
`define RST_CTRL_PRIMARY    8'h00
`define RST_XCVR_CONFIG     8'h00
`define RST_MODE_SPEED      8'h00

// ********************************************************
// Timing
// ********************************************************
`define CLK_MHZ             25
`define STEP_NS             300
`define STEP_CYCLES         ((`STEP_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### pin_sync.v
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync
#(
    parameter WIDTH = 3
)
(
    input  wire             clk,
    input  wire             srst,
    input  wire             ce,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    genvar i;

    // ********************************************************
    // One two-stage chain per bit
    // ********************************************************
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_chain
            reg meta_q;
            reg stable_q;
            // First stage is read by the second stage only
            always @(posedge clk)
            begin
                if (srst)
                begin
                    meta_q   <= 1'b1;
                    stable_q <= 1'b1;
                end
                else if (ce)
                begin
                    meta_q   <= async_in[i];
                    stable_q <= meta_q;
                end
            end
            assign sync_out[i] = stable_q;
        end
    endgenerate
endmodule // pin_sync

// ### ir_xcvr_if_asserts.sv
// Concurrent checks on the transceiver interface ports
`timescale 1ns/1ns
module ir_xcvr_chk
(
    input wire        clk,
    input wire        srst,
    input wire        ce,
    input wire [7:0]  paddr,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire        pslverr,
    input wire        power_down_n,
    input wire        ir_tx_out,
    input wire        module_shutdown_out,
    input wire        osc_stop,
    input wire        powered_down
);
// ********************************************************
// Shadow of the settings the pin checks depend on
// ********************************************************
reg       sdpol_q;
reg       xtal_q;
reg       fir_q;
reg [4:0] busy_q;
wire      wr = psel & penable & pready & pwrite & pstrb[0];
wire      go = wr & (paddr == 8'h10) & pwdata[7] & !xtal_q & !powered_down & (busy_q == 5'h00);
// Busy window spans pulse and tail, so no shutdown edge is misread
always @(posedge clk)
begin
    if (srst)
    begin
        sdpol_q <= 1'b0;
        xtal_q  <= 1'b0;
        fir_q   <= 1'b0;
        busy_q  <= 5'h00;
    end
    else if (ce)
    begin
        if (wr && paddr == 8'h14)
            sdpol_q <= pwdata[6];
        if (wr && paddr == 8'h18)
        begin
            xtal_q <= pwdata[4];
            fir_q  <= pwdata[6:5] == 2'h3;
        end
        busy_q <= go ? 5'h14 : (busy_q != 5'h00) ? busy_q - 5'h01 : 5'h00;
    end
end
// ********************************************************
// Properties
// ********************************************************
default clocking @(posedge clk); endclocking
default disable iff (srst || !ce);
AST_READY: assert property (psel && !penable |=> pready) else $error("no pready");
AST_UNMAPPED: assert property (psel && penable && pready && !(paddr[7:2] inside {6'h04, 6'h05, 6'h06, 6'h08})
    |-> pslverr) else $error("no pslverr");
AST_PD_ENTER: assert property (!power_down_n [*3] |=> powered_down) else $error("no power-down");
AST_OSC: assert property (osc_stop == powered_down) else $error("osc_stop differs");
AST_PD_TX: assert property (powered_down |-> !ir_tx_out) else $error("tx while down");
AST_PD_SD: assert property (powered_down && $stable(sdpol_q) |-> module_shutdown_out != sdpol_q)
    else $error("shutdown level");
AST_FOLLOW: assert property ($changed(power_down_n) && busy_q == 5'h00 |-> ##3 $changed(module_shutdown_out))
    else $error("shutdown not following");
AST_MS_SD: assert property (go |-> ##2 (module_shutdown_out != sdpol_q) [*8] ##1 (module_shutdown_out == sdpol_q))
    else $error("mode-set pulse");
AST_MS_FIR: assert property (go && fir_q |-> ##2 ir_tx_out [*8] ##1 ir_tx_out [*8])
    else $error("fir tx");
AST_MS_LOW: assert property (go && !fir_q |-> ##2 !ir_tx_out [*8] ##1 !ir_tx_out [*8])
    else $error("slow tx");
endmodule // ir_xcvr_chk

bind ir_xcvr_if ir_xcvr_chk chk_u (.clk(clk), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .power_down_n(power_down_n), .ir_tx_out(ir_tx_out), .module_shutdown_out(module_shutdown_out),
    .osc_stop(osc_stop), .powered_down(powered_down));

// ### ir_module_model.sv
// Behavioural infrared transceiver module on the far side of the pins
`timescale 1ns/1ns
module ir_module_model
(
    input  wire       clk,
    input  wire       sd_hi,
    input  wire       rx_hi,
    input  wire       pulse_a,
    input  wire       pulse_b,
    input  wire       module_shutdown_out,
    input  wire       ir_tx_out,
    output wire       ir_rx_in_a,
    output wire       ir_rx_in_b,
    output reg  [4:0] pulse_len,
    output reg        fir_latch
);
wire      off = (module_shutdown_out == sd_hi);
reg [4:0] run_q;
reg       off_q;
// Receivers fall quiet while shut down
assign ir_rx_in_a = (pulse_a & !off) ^ !rx_hi;
assign ir_rx_in_b = (pulse_b & !off) ^ !rx_hi;
// Mode is taken from the transmit pin as shutdown ends
always @(posedge clk)
begin
    off_q <= off;
    run_q <= off ? run_q + 5'h01 : 5'h00;
    if (off_q && !off)
    begin
        pulse_len <= run_q;
        fir_latch <= ir_tx_out;
    end
end
endmodule // ir_module_model

// ### testbench.sv
// Self-checking bench for the transceiver interface
`timescale 1ns/1ns
module testbench;
reg         clk, srst, psel, penable, pwrite, er;
reg  [7:0]  paddr;
reg  [31:0] pwdata, rd;
reg  [3:0]  pstrb;
reg         power_down_n, tx_data, pulse_a, pulse_b, sd_hi, rx_hi;
wire [31:0] prdata;
wire        pready, pslverr, ir_tx_out, module_shutdown_out, rx_pulse, osc_stop, powered_down;
wire        ir_rx_in_a, ir_rx_in_b, fir_latch;
wire [4:0]  pulse_len;
integer     num_errors, check_count, i;
ir_xcvr_if dut_u (.clk(clk), .srst(srst), .ce(1'b1), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_down_n(power_down_n), .ir_rx_in_a(ir_rx_in_a), .ir_rx_in_b(ir_rx_in_b), .tx_data(tx_data),
    .ir_tx_out(ir_tx_out), .module_shutdown_out(module_shutdown_out), .rx_pulse(rx_pulse),
    .osc_stop(osc_stop), .powered_down(powered_down));
ir_module_model mod_u (.clk(clk), .sd_hi(sd_hi), .rx_hi(rx_hi), .pulse_a(pulse_a), .pulse_b(pulse_b),
    .module_shutdown_out(module_shutdown_out), .ir_tx_out(ir_tx_out), .ir_rx_in_a(ir_rx_in_a),
    .ir_rx_in_b(ir_rx_in_b), .pulse_len(pulse_len), .fir_latch(fir_latch));
// ********************************************************
// Reporting and bus tasks
// ********************************************************
task print_verdict;
begin
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
end
endtask
task chk(input [31:0] got, input [31:0] exp);
begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
end
endtask
// Answer sampled at the rising edge; request released right after it
task apb(input [7:0] a, input w, input [31:0] d);
    integer n;
begin
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
        n = n + 1;
        if (n > 20)
        begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED at %0t: bus hang", $time);
            print_verdict;
        end
        @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
end
endtask
task rchk(input [7:0] a, input [31:0] exp);
begin
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
end
endtask
task cyc(input integer n);
begin
    repeat (n) @(posedge clk);
end
endtask
// ********************************************************
// Clock and main sequence
// ********************************************************
initial
begin
    clk = 1'b0;
    forever #20 clk = ~clk;
end
initial
begin
    {srst, psel, penable, pwrite, paddr, pwdata, pstrb} = {4'h8, 8'h0, 32'h0, 4'hf};
    {power_down_n, tx_data, pulse_a, pulse_b, sd_hi, rx_hi} = 6'h23;
    num_errors = 0;
    check_count = 0;
    cyc(12);
    srst <= 1'b0;
    rchk(8'h10, 32'h0);
    rchk(8'h14, 32'h0);
    rchk(8'h18, 32'h0);
    apb(8'h24, 1'b0, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    // Lane gate, then full write with read-only bits dropped
    pstrb <= 4'h0;
    apb(8'h14, 1'b1, 32'h70);
    pstrb <= 4'hf;
    rchk(8'h14, 32'h0);
    apb(8'h14, 1'b1, 32'hff);
    rchk(8'h14, 32'h70);
    apb(8'h18, 1'b1, 32'h1f);
    rchk(8'h18, 32'h1f);
    apb(8'h10, 1'b1, 32'h80);
    rchk(8'h10, 32'h0);
    apb(8'h18, 1'b1, 32'h18);
    apb(8'h20, 1'b0, 32'h0);
    chk(rd & 32'h20, 32'h20);
    // Receive path over select, speed, pin and polarity
    apb(8'h10, 1'b1, 32'h02);
    for (i = 0; i < 16; i = i + 1)
    begin
        rx_hi <= i[0];
        apb(8'h14, 1'b1, {26'h0, i[1], i[0], 4'h0});
        apb(8'h18, 1'b1, i[2] ? 32'h06 : 32'h02);
        pulse_a <= !i[3];
        pulse_b <= i[3];
        cyc(4);
        chk(rx_pulse, i[3] == (i[1] & i[2]));
        pulse_a <= 1'b0;
        pulse_b <= 1'b0;
        cyc(4);
    end
    // Transmit pin, then power-down at both shutdown polarities
    apb(8'h10, 1'b1, 32'h01);
    tx_data <= 1'b1;
    cyc(3);
    chk(ir_tx_out, 1);
    for (i = 0; i < 2; i = i + 1)
    begin
        apb(8'h14, 1'b1, i ? 32'h40 : 32'h0);
        cyc(2);
        chk(module_shutdown_out, i);
        power_down_n <= 1'b0;
        cyc(4);
        chk({ir_tx_out, module_shutdown_out}, !i);
        chk({osc_stop, powered_down}, 3);
        power_down_n <= 1'b1;
        cyc(4);
    end
    tx_data <= 1'b0;
    // Mode-set sequence in fast and slow modes, both polarities
    for (i = 0; i < 4; i = i + 1)
    begin
        sd_hi <= !i[1];
        apb(8'h14, 1'b1, {25'h0, i[1], 6'h0});
        apb(8'h18, 1'b1, i[0] ? 32'h68 : 32'h02);
        apb(8'h10, 1'b1, 32'h80);
        rchk(8'h10, 32'h80);
        cyc(24);
        rchk(8'h10, 32'h0);
        chk(pulse_len, 8);
        chk(fir_latch, i[0]);
    end
    // Host bring-up order; DMA, interrupt and FIFO set-up sit outside this block
    apb(8'h18, 1'b1, 32'h01);
    apb(8'h14, 1'b1, 32'h70);
    rchk(8'h18, 32'h01);
    rchk(8'h14, 32'h70);
    apb(8'h20, 1'b0, 32'h0);
    chk(rd & 32'h28, 32'h00);
    print_verdict;
end
endmodule // testbench
